/* File: src/rail_seq_defs.svh */
`ifndef RAIL_SEQ_DEFS_SVH
`define RAIL_SEQ_DEFS_SVH

// register command codes
`define ORDER_CODE       8'hE0
`define GROUP_CODE       8'hE2
// ordering register layout
`define ORDER_RESET      16'h0000
`define ORDER_WMASK      16'h9F9F
`define ORD_PRE_EN       15
`define ORD_PRE_HI       12
`define ORD_PRE_LO       8
`define ORD_SUC_EN       7
`define ORD_SUC_HI       4
`define ORD_SUC_LO       0
// group register layout
`define GROUP_WMASK      32'h003F3F3F
`define GRP_VOUT_EN      21
`define GRP_VOUT_HI      20
`define GRP_VOUT_LO      16
`define GRP_OP_EN        13
`define GRP_OP_HI        12
`define GRP_OP_LO        8
`define GRP_PF_NOW       5
`define GRP_PF_HI        4
`define GRP_PF_LO        0
// event bus opcodes
`define EV_PGOOD         3'h1
`define EV_PDOWN         3'h2
`define EV_VOUT          3'h3
`define EV_OPER          3'h4
`define EV_PFAIL         3'h5

`endif

/* File: src/rail_seq_pkg.sv */
package rail_seq_pkg;
    typedef logic [4:0] id_t;
    typedef logic [2:0] ev_op_t;
    typedef enum logic [2:0] {ST_OFF, ST_WAIT_PRE, ST_ON, ST_WAIT_SUC, ST_RAMP_DOWN} rail_state_e;
endpackage

/* File: src/event_match.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// group or rail id match for one event kind
// ************************************************************
module event_match (
    input  wire logic       ev_valid,
    input  wire logic [2:0] ev_op,
    input  wire logic [4:0] ev_id,
    input  wire logic [2:0] want_op,
    input  wire logic       enable,
    input  wire logic [4:0] want_id,
    output logic            hit
);
    // qualified compare
    assign hit = ev_valid && enable && (ev_op == want_op) && (ev_id == want_id);
endmodule // event_match
`default_nettype wire

/* File: src/multirail_sequence_groups.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rail_seq_defs.svh"

// Function
// RULE1: with predecessor ordering on, the output turns on only after enable and a matching power-good event.
// RULE2: with successor ordering on, delayed shutdown starts only after the successor's power-down event.
// RULE3: ordering bit 15 enables the predecessor and bits 12:8 hold its rail id, bits 14:13 unused.
// RULE4: ordering bit 7 enables the successor and bits 4:0 hold its rail id, bits 6:5 unused.
// RULE5: the ordering register reads zero after reset.
// RULE6: a write to the ordering register overrides ordering taken from the strap.
// RULE7: group bit 21 gates response to broadcast output-voltage events matching bits 20:16.
// RULE8: group bit 13 gates response to broadcast operation events matching bits 12:8.
// RULE9: a supply-loss event with own group id shuts down at once if bit 5 set, else sequenced.
// RULE10: group bits 4:0 are the id sent in supply-loss events this converter sends.
// RULE11: group bits 12:8 are the id sent in operation events this converter sends.
// RULE12: rails sharing current must be given the same group id by whoever configures them.
// RULE13: in two-phase sharing mode supply-loss responses reach both phases regardless of group setup.
// RULE14: broadcast matching uses group ids only and ordering uses rail ids only.
// RULE15: after reset the group register loads from the decoded strap value.
// RULE16: the converter announces its own power-good and ramp-down completion on the event bus.
module multirail_sequence_groups
    import rail_seq_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                reset,
    input  wire logic                wr_en,
    input  wire logic                rd_en,
    input  wire logic [7:0]          reg_code,
    input  wire logic [31:0]         wr_data,
    output logic [31:0]              rd_data,
    output logic                     rd_valid,
    input  wire logic [31:0]         strap_group,
    input  wire logic [15:0]         strap_order,
    input  wire logic                two_phase_share,
    input  wire logic                enable_req,
    input  wire logic                power_good,
    input  wire logic                ramp_done,
    input  wire logic                ev_in_valid,
    input  wire rail_seq_pkg::ev_op_t ev_in_op,
    input  wire rail_seq_pkg::id_t   ev_in_id,
    input  wire logic [15:0]         ev_in_data,
    input  wire logic                send_pfail,
    input  wire logic                send_oper,
    output logic                     ev_out_valid,
    output rail_seq_pkg::ev_op_t     ev_out_op,
    output rail_seq_pkg::id_t        ev_out_id,
    output logic                     output_on,
    output logic                     fast_off,
    output logic                     vout_load,
    output logic [15:0]              vout_value,
    output logic                     oper_load,
    output logic [7:0]               oper_value,
    output logic                     pfail_both_phases,
    input  wire rail_seq_pkg::id_t   own_rail_id
);
    import rail_seq_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        rail_state_e  st;
        logic [15:0]  order;
        logic         order_written;
        logic [31:0]  group;
        logic         pg_prev;
        logic         rd_prev;
        logic [31:0]  rdata;
        logic         rvalid;
        logic         evv;
        ev_op_t       evop;
        id_t          evid;
        logic         fast;
        logic         vld;
        logic [15:0]  vval;
        logic         old;
        logic [7:0]   oval;
        logic         pf2;
        logic         strap_done;
        logic [15:0]  strap_ord;
        logic         out_on;
    } state_s;

    state_s s_q, s_d;
    logic   hit_pre, hit_suc, hit_vout, hit_op, hit_pf, pf_match;
    logic   pre_en, suc_en;
    logic [15:0] eff_order;

    // effective ordering: register once written, else strap
    assign eff_order = s_q.order_written ? s_q.order : s_q.strap_ord; // [RULE6]
    assign pre_en = eff_order[`ORD_PRE_EN];
    assign suc_en = eff_order[`ORD_SUC_EN];

    // ************************************************************
    // event matchers
    // ************************************************************
    // rail ids for ordering only, group ids for broadcasts
    event_match u_pre (.ev_valid(ev_in_valid), .ev_op(ev_in_op), .ev_id(ev_in_id),
        .want_op(`EV_PGOOD), .enable(pre_en),
        .want_id(eff_order[`ORD_PRE_HI:`ORD_PRE_LO]), .hit(hit_pre)); // [RULE1] [RULE14]
    event_match u_suc (.ev_valid(ev_in_valid), .ev_op(ev_in_op), .ev_id(ev_in_id),
        .want_op(`EV_PDOWN), .enable(suc_en),
        .want_id(eff_order[`ORD_SUC_HI:`ORD_SUC_LO]), .hit(hit_suc)); // [RULE2] [RULE14]
    event_match u_vout (.ev_valid(ev_in_valid), .ev_op(ev_in_op), .ev_id(ev_in_id),
        .want_op(`EV_VOUT), .enable(s_q.group[`GRP_VOUT_EN]),
        .want_id(s_q.group[`GRP_VOUT_HI:`GRP_VOUT_LO]), .hit(hit_vout)); // [RULE7]
    event_match u_op (.ev_valid(ev_in_valid), .ev_op(ev_in_op), .ev_id(ev_in_id),
        .want_op(`EV_OPER), .enable(s_q.group[`GRP_OP_EN]),
        .want_id(s_q.group[`GRP_OP_HI:`GRP_OP_LO]), .hit(hit_op)); // [RULE8]
    event_match u_pf (.ev_valid(ev_in_valid), .ev_op(ev_in_op), .ev_id(ev_in_id),
        .want_op(`EV_PFAIL), .enable(1'b1),
        .want_id(s_q.group[`GRP_PF_HI:`GRP_PF_LO]), .hit(pf_match)); // [RULE9]
    assign hit_pf = pf_match;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.evv = 1'b0;
        s_d.vld = 1'b0;
        s_d.old = 1'b0;
        s_d.pg_prev = power_good;
        s_d.rd_prev = ramp_done;
        s_d.pf2 = two_phase_share; // [RULE13]
        // strap load one cycle after reset release
        if (!s_q.strap_done) begin
            s_d.strap_done = 1'b1;
            s_d.group = strap_group & `GROUP_WMASK; // [RULE15]
            // strap ordering kept apart so the register still reads zero
            s_d.strap_ord = strap_order & `ORDER_WMASK; // [RULE5] [RULE6]
        end
        // register writes, write wins over strap
        if (wr_en && reg_code == `ORDER_CODE) begin
            s_d.order = wr_data[15:0] & `ORDER_WMASK; // [RULE3] [RULE4] [RULE6]
            s_d.order_written = 1'b1;
        end else if (wr_en && reg_code == `GROUP_CODE) begin
            s_d.group = wr_data & `GROUP_WMASK;
        end
        // register reads
        if (rd_en) begin
            s_d.rvalid = 1'b1;
            if (reg_code == `ORDER_CODE) begin
                s_d.rdata = {16'h0000, s_q.order};
            end else if (reg_code == `GROUP_CODE) begin
                s_d.rdata = s_q.group;
            end else begin
                s_d.rdata = 32'h0000_0000;
            end
        end
        // broadcast responses
        if (hit_vout) begin
            s_d.vld = 1'b1;
            s_d.vval = ev_in_data;
        end
        if (hit_op) begin
            s_d.old = 1'b1;
            s_d.oval = ev_in_data[7:0];
        end
        // sequencing
        case (s_q.st)
            ST_OFF: begin
                s_d.fast = 1'b0;
                if (enable_req) begin
                    s_d.st = pre_en ? ST_WAIT_PRE : ST_ON;
                end
            end
            ST_WAIT_PRE: begin
                if (!enable_req) begin
                    s_d.st = ST_OFF;
                end else if (hit_pre) begin
                    s_d.st = ST_ON; // [RULE1]
                end
            end
            ST_ON: begin
                if (!enable_req) begin
                    s_d.st = suc_en ? ST_WAIT_SUC : ST_RAMP_DOWN;
                end
            end
            ST_WAIT_SUC: begin
                if (hit_suc) begin
                    s_d.st = ST_RAMP_DOWN; // [RULE2]
                end
            end
            ST_RAMP_DOWN: begin
                if (ramp_done) begin
                    s_d.st = ST_OFF;
                end
            end
            default: s_d.st = ST_OFF;
        endcase
        // supply loss overrides the sequence
        if (hit_pf && (s_q.st == ST_ON || s_q.st == ST_WAIT_SUC)) begin
            if (s_q.group[`GRP_PF_NOW]) begin
                s_d.st = ST_OFF; // [RULE9]
                s_d.fast = 1'b1;
            end else begin
                s_d.st = suc_en ? ST_WAIT_SUC : ST_RAMP_DOWN; // [RULE9]
            end
        end
        // outgoing events
        if (power_good && !s_q.pg_prev) begin
            s_d.evv = 1'b1;
            s_d.evop = `EV_PGOOD; // [RULE16]
            s_d.evid = own_rail_id;
        end else if (ramp_done && !s_q.rd_prev) begin
            s_d.evv = 1'b1;
            s_d.evop = `EV_PDOWN; // [RULE16]
            s_d.evid = own_rail_id;
        end else if (send_pfail) begin
            s_d.evv = 1'b1;
            s_d.evop = `EV_PFAIL;
            s_d.evid = s_q.group[`GRP_PF_HI:`GRP_PF_LO]; // [RULE10]
        end else if (send_oper) begin
            s_d.evv = 1'b1;
            s_d.evop = `EV_OPER;
            s_d.evid = s_q.group[`GRP_OP_HI:`GRP_OP_LO]; // [RULE11]
        end
        // output enable registered with the state
        s_d.out_on = (s_d.st == ST_ON) || (s_d.st == ST_WAIT_SUC);
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clock) begin
        if (reset) begin
            s_q <= '0;
            s_q.st <= ST_OFF;
            s_q.order <= `ORDER_RESET; // [RULE5]
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign rd_data = s_q.rdata;
    assign rd_valid = s_q.rvalid;
    assign ev_out_valid = s_q.evv;
    assign ev_out_op = s_q.evop;
    assign ev_out_id = s_q.evid;
    assign output_on = s_q.out_on;
    assign fast_off = s_q.fast;
    assign vout_load = s_q.vld;
    assign vout_value = s_q.vval;
    assign oper_load = s_q.old;
    assign oper_value = s_q.oval;
    assign pfail_both_phases = s_q.pf2;

    // ************************************************************
    // checks
    // ************************************************************
    sequence pre_seen;
        hit_pre && s_q.st == ST_WAIT_PRE && enable_req;
    endsequence
    chk_pre_gate_on: assert property (@(posedge clock) disable iff (reset) // [RULE1]
        $rose(output_on) && pre_en |-> $past(hit_pre))
        else $error("output rose without predecessor power good");
    chk_pre_then_on: assert property (@(posedge clock) disable iff (reset) // [RULE1]
        pre_seen |=> output_on)
        else $error("predecessor event did not turn output on");
    chk_suc_wait: assert property (@(posedge clock) disable iff (reset) // [RULE2]
        s_q.st == ST_WAIT_SUC && !hit_suc && !hit_pf |=> s_q.st == ST_WAIT_SUC)
        else $error("shutdown began before successor event");
    chk_order_unused: assert property (@(posedge clock) disable iff (reset) // [RULE3]
        (s_q.order & ~`ORDER_WMASK) == 16'h0000)
        else $error("unused ordering bits set");
    chk_order_write: assert property (@(posedge clock) disable iff (reset) // [RULE6]
        wr_en && reg_code == `ORDER_CODE |=> s_q.order == ($past(wr_data[15:0]) & `ORDER_WMASK))
        else $error("ordering write not taken");
    chk_pf_fast: assert property (@(posedge clock) disable iff (reset) // [RULE9]
        hit_pf && output_on && s_q.group[`GRP_PF_NOW] |=> !output_on && fast_off)
        else $error("immediate shutdown missed");
    chk_pf_id_out: assert property (@(posedge clock) disable iff (reset) // [RULE10]
        ev_out_valid && ev_out_op == `EV_PFAIL |->
        ev_out_id == $past(s_q.group[`GRP_PF_HI:`GRP_PF_LO]))
        else $error("supply loss event id wrong");
    chk_vout_gate: assert property (@(posedge clock) disable iff (reset) // [RULE7]
        vout_load |-> $past(s_q.group[`GRP_VOUT_EN]))
        else $error("output voltage event taken while disabled");
endmodule // multirail_sequence_groups
`default_nettype wire

/* File: testbench/peer_rail_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// peer converter driving the shared event bus
// ************************************************************
module peer_rail_model
    import rail_seq_pkg::*;
(
    input  wire logic         clock,
    output logic              ev_valid,
    output rail_seq_pkg::ev_op_t ev_op,
    output rail_seq_pkg::id_t ev_id,
    output logic [15:0]       ev_data
);
    import rail_seq_pkg::*;

    // bus idle at time zero
    initial begin
        ev_valid = 1'b0;
        ev_op    = 3'h0;
        ev_id    = 5'h00;
        ev_data  = 16'h0000;
    end

    // one-cycle event; a peer in a sharing group sends the shared group id
    task send_event(input ev_op_t op, input id_t id, input logic [15:0] data);
        @(negedge clock);
        ev_valid = 1'b1;
        ev_op    = op;
        ev_id    = id;
        ev_data  = data;
        @(negedge clock);
        ev_valid = 1'b0;
        ev_op    = ~op; // released lines show no stale value
        ev_id    = ~id;
        ev_data  = ~data;
    endtask
endmodule // peer_rail_model
`default_nettype wire

/* File: testbench/multirail_sequence_groups_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rail_seq_defs.svh"
module multirail_sequence_groups_test;
    import rail_seq_pkg::*;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [7:0]  reg_code = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic [31:0] strap_group = 32'h00252A27;
    logic [15:0] strap_order = 16'h0000;
    logic        two_phase_share = 1'b0;
    logic        enable_req = 1'b0;
    logic        power_good = 1'b0;
    logic        ramp_done = 1'b0;
    logic        send_pfail = 1'b0;
    logic        send_oper = 1'b0;
    id_t         own_rail_id = 5'h1C;
    logic [31:0] rd_data, d;
    logic        rd_valid, ev_in_valid, ev_out_valid, output_on, fast_off;
    logic        vout_load, oper_load, pfail_both_phases;
    ev_op_t      ev_in_op, ev_out_op;
    id_t         ev_in_id, ev_out_id;
    logic [15:0] ev_in_data, vout_value;
    logic [7:0]  oper_value;
    logic        vout_seen, oper_seen, ev_seen, fast_seen;
    int          error_cnt = 0;
    int          comparisons = 0;

    multirail_sequence_groups u_multirail_sequence_groups (.clock(clock), .reset(reset),
        .wr_en(wr_en), .rd_en(rd_en), .reg_code(reg_code), .wr_data(wr_data),
        .rd_data(rd_data), .rd_valid(rd_valid), .strap_group(strap_group),
        .strap_order(strap_order), .two_phase_share(two_phase_share),
        .enable_req(enable_req), .power_good(power_good), .ramp_done(ramp_done),
        .ev_in_valid(ev_in_valid), .ev_in_op(ev_in_op), .ev_in_id(ev_in_id),
        .ev_in_data(ev_in_data), .send_pfail(send_pfail), .send_oper(send_oper),
        .ev_out_valid(ev_out_valid), .ev_out_op(ev_out_op), .ev_out_id(ev_out_id),
        .output_on(output_on), .fast_off(fast_off), .vout_load(vout_load),
        .vout_value(vout_value), .oper_load(oper_load), .oper_value(oper_value),
        .pfail_both_phases(pfail_both_phases), .own_rail_id(own_rail_id));
    peer_rail_model u_peer_rail_model (.clock(clock), .ev_valid(ev_in_valid),
        .ev_op(ev_in_op), .ev_id(ev_in_id), .ev_data(ev_in_data));

    // ************************************************************
    // clock and pulse catchers
    // ************************************************************
    initial begin
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        if (vout_load) vout_seen <= 1'b1;
        if (oper_load) oper_seen <= 1'b1;
        if (ev_out_valid) ev_seen <= 1'b1;
        if (fast_off) fast_seen <= 1'b1;
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task step(input int n);
        repeat (n) @(negedge clock);
    endtask
    task clr;
        vout_seen = 1'b0;
        oper_seen = 1'b0;
        ev_seen   = 1'b0;
        fast_seen = 1'b0;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task do_reset;
        reset = 1'b1;
        step(6);
        reset = 1'b0;
        step(2);
    endtask
    task reg_write(input logic [7:0] code, input logic [31:0] data);
        reg_code = code;
        wr_data  = data;
        wr_en    = 1'b1;
        step(1);
        wr_en    = 1'b0;
        step(1);
    endtask
    task reg_read(input logic [7:0] code, output logic [31:0] data);
        int i;
        reg_code = code;
        rd_en    = 1'b1;
        step(1);
        rd_en    = 1'b0;
        for (i = 0; i < 4 && rd_valid !== 1'b1; i++) step(1);
        if (rd_valid !== 1'b1) begin
            error_cnt++;
            end_sim();
        end
        data = rd_data;
        step(1);
    endtask
    task ev(input ev_op_t op, input id_t id, input logic [15:0] data);
        clr();
        u_peer_rail_model.send_event(op, id, data);
        step(2);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task t_regs;
        reg_read(`ORDER_CODE, d);
        check(d, 32'h0);
        reg_read(`GROUP_CODE, d);
        check(d, 32'h00252A27);
        reg_write(`ORDER_CODE, 32'hFFFFFFFF);
        reg_read(`ORDER_CODE, d);
        check(d, 32'h00009F9F);
        reg_write(`GROUP_CODE, 32'hFFFFFFFF);
        reg_read(`GROUP_CODE, d);
        check(d, 32'h003F3F3F);
        reg_read(8'hE1, d);
        check(d, 32'h0);
        reg_write(`GROUP_CODE, 32'h00252A27);
    endtask
    task t_override;
        strap_order = 16'h8304;
        do_reset();
        reg_read(`ORDER_CODE, d);
        check(d, 32'h0);
        enable_req = 1'b1;
        step(3);
        check(output_on, 1'b0);
        enable_req = 1'b0;
        step(2);
        reg_write(`ORDER_CODE, 32'h00008405);
        reg_read(`ORDER_CODE, d);
        check(d, 32'h00008405);
    endtask
    task t_pre_suc;
        reg_write(`ORDER_CODE, 32'h00008300);
        enable_req = 1'b1;
        step(3);
        check(output_on, 1'b0);
        ev(`EV_PGOOD, 5'h0A, 16'h0);
        check(output_on, 1'b0);
        ev(`EV_PGOOD, 5'h03, 16'h0);
        check(output_on, 1'b1);
        clr();
        power_good = 1'b1;
        step(3);
        check({ev_seen, ev_out_op, ev_out_id}, {1'b1, `EV_PGOOD, own_rail_id});
        reg_write(`ORDER_CODE, 32'h00000087);
        enable_req = 1'b0;
        step(3);
        check(output_on, 1'b1);
        ev(`EV_PDOWN, 5'h03, 16'h0);
        check(output_on, 1'b1);
        ev(`EV_PDOWN, 5'h07, 16'h0);
        check(output_on, 1'b0);
        power_good = 1'b0;
        ramp_done = 1'b1;
        step(3);
        check({ev_seen, ev_out_op, ev_out_id}, {1'b1, `EV_PDOWN, own_rail_id});
        ramp_done = 1'b0;
    endtask
    task t_bcast;
        ev(`EV_VOUT, 5'h05, 16'h1234); // shared group id
        check({vout_seen, vout_value}, {1'b1, 16'h1234});
        ev(`EV_OPER, 5'h05, 16'h0033);
        check(oper_seen, 1'b0);
        ev(`EV_OPER, 5'h0A, 16'h00C5);
        check({oper_seen, oper_value}, {1'b1, 8'hC5});
        reg_write(`GROUP_CODE, 32'h00050A27);
        ev(`EV_VOUT, 5'h05, 16'h4321);
        check(vout_seen, 1'b0);
        ev(`EV_OPER, 5'h0A, 16'h005A);
        check({vout_seen, oper_seen}, 2'b00);
        reg_write(`GROUP_CODE, 32'h00252A27);
    endtask
    task t_pfail;
        reg_write(`ORDER_CODE, 32'h0);
        enable_req = 1'b1;
        step(3);
        clr();
        u_peer_rail_model.send_event(`EV_PFAIL, 5'h07, 16'h0);
        check({output_on, fast_off}, 2'b01);
        step(3);
        reg_write(`GROUP_CODE, 32'h00252A07);
        ev(`EV_PFAIL, 5'h07, 16'h0);
        check({output_on, fast_seen}, 2'b00);
        enable_req = 1'b0;
        ramp_done = 1'b1;
        two_phase_share = 1'b1;
        step(2);
        check(pfail_both_phases, 1'b1);
        ramp_done = 1'b0;
        two_phase_share = 1'b0;
    endtask
    task t_send;
        clr();
        send_pfail = 1'b1;
        step(1);
        send_pfail = 1'b0;
        step(2);
        check({ev_seen, ev_out_op, ev_out_id}, {1'b1, `EV_PFAIL, 5'h07});
        clr();
        send_oper = 1'b1;
        step(1);
        send_oper = 1'b0;
        step(2);
        check({ev_seen, ev_out_op, ev_out_id}, {1'b1, `EV_OPER, 5'h0A});
    endtask

    // main sequence
    initial begin
        clr();
        do_reset();
        t_regs();
        t_override();
        t_pre_suc();
        t_bcast();
        t_pfail();
        t_send();
        end_sim();
    end
endmodule // multirail_sequence_groups_test
`default_nettype wire
